// File: logic_cell_array.v
// Function
// (R1) Each cell ORs at most eight array product terms; the sum feeds that cell.
// (R2) Two global bits plus one cell bit steer four muxes per cell.
// (R3) Eight cells, each registered, combinatorial output, combinatorial I/O or input.
// (R4) Every array input offers true and inverted copies to the AND array.
// (R5) Clock and enable pins are array inputs or shared clock and output enable.
// (R6) Empty product term is high; true plus complement of one input is low.
// (R7) Registered cells drive only while the shared enable pin is active.
// (R8) Combinatorial cells drive from a product term or always, per configuration.
// (R9) Input cells never drive; their feedback is the neighbour cell's pin.
// (R10) Configuration word: two global bits, eight mode bits, eight polarity bits.
// (R11) Register-allow bit permits registers; family bit picks registered or combinatorial.
// (R12) Polarity bit XORs the OR output: 1 inverts, 0 passes.
// (R13) Family and mode bits steer muxes; end cells use register-allow for feedback.
// (R14) Clock and enable pins feed the array only when registers are disallowed.
// (R15) Registered mode is 0,1,0; eight terms, polarity-adjusted, feed the flip-flop.
// (R16) Cell flip-flop loads on clock-pin rising edge; feedback comes from it.
// (R17) Dedicated output is 1,0,0, eight terms; two cells give no feedback.
// (R18) Dedicated input is 1,0,1; driver off, feedback from adjacent pin.
// (R19) Combinatorial I/O 1,1,1: seven terms summed, eighth enables, pin fed back; end cells 0 and 7 feed back the neighbour cell's pin.
// (R20) Registered-device I/O 0,1,1: seven terms, eighth enables, pin fed back.
// (R21) Configuration is static; all cell mux selects derive combinationally from it.
`timescale 1ns/1ps
`default_nettype none
`include "logic_cell_array_defines.vh"

module logic_cell_array (
    input wire clock,
    input wire rst_n,
    input wire [`NUM_DIN-1:0] dataIn,
    input wire clockPin,
    input wire outEnablePin_n,
    input wire [`NUM_CELLS-1:0] cellPinIn,
    output reg [`NUM_CELLS-1:0] cellPinOut,
    output reg [`NUM_CELLS-1:0] cellPinOe,
    input wire awvalid,
    output reg awready,
    input wire [`ADDR_W-1:0] awaddr,
    input wire wvalid,
    output reg wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    input wire arvalid,
    output reg arready,
    input wire [`ADDR_W-1:0] araddr,
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp
);

    // -----------------------------------------------------------------
    // Reset release
    // -----------------------------------------------------------------

    reg [1:0] rstSync_reg;
    wire rstSafe_n;

    // Two-stage release so deassertion is clean against the clock
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_reg <= 2'b00;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end

    assign rstSafe_n = rstSync_reg[1];

    // -----------------------------------------------------------------
    // Storage: configuration word and fuse map
    // -----------------------------------------------------------------

    reg [`CFG_W-1:0] config_reg;
    reg [`NUM_SIG-1:0] fuseTrue_reg [0:`NUM_TERMS-1];
    reg [`NUM_SIG-1:0] fuseComp_reg [0:`NUM_TERMS-1];
    reg [`NUM_CELLS-1:0] cellQ_reg;
    reg clkPinPrev_reg;

    // Static configuration fields; every mux select below is pure logic
    wire regAllow = config_reg[`CFG_REG_ALLOW_BIT]; // [R10] [R11] [R21]
    wire familySel = config_reg[`CFG_FAMILY_BIT]; // [R10] [R11]
    wire [`NUM_CELLS-1:0] modeBits = config_reg[`CFG_MODE_LSB +: `NUM_CELLS]; // [R10]
    wire [`NUM_CELLS-1:0] polBits = config_reg[`CFG_POL_LSB +: `NUM_CELLS]; // [R10]

    // -----------------------------------------------------------------
    // AND array
    // -----------------------------------------------------------------

    wire [`NUM_CELLS-1:0] feedback;
    wire [`NUM_SIG-1:0] arraySig;
    wire [`NUM_SIG-1:0] colMask;
    wire [`NUM_TERMS-1:0] termVal;

    // Array columns: data pins, clock pin, enable pin, cell feedback
    assign arraySig = {feedback, outEnablePin_n, clockPin, dataIn}; // [R5]

    // Clock and enable columns are dead while registers are in use
    assign colMask = regAllow ? {`NUM_SIG{1'b1}} :
        ~(({{(`NUM_SIG-1){1'b0}}, 1'b1} << `SIG_CLK) |
          ({{(`NUM_SIG-1){1'b0}}, 1'b1} << `SIG_OE)); // [R14]

    // An unconnected literal reads as one, so an empty term is high and
    // a term holding both polarities of one column is always low
    genvar t;
    generate
        for (t = 0; t < `NUM_TERMS; t = t + 1) begin : gTerm
            wire [`NUM_SIG-1:0] useTrue = fuseTrue_reg[t] & colMask;
            wire [`NUM_SIG-1:0] useComp = fuseComp_reg[t] & colMask;
            assign termVal[t] = (&(~useTrue | arraySig)) &
                (&(~useComp | ~arraySig)); // [R4] [R6]
        end
    endgenerate

    // -----------------------------------------------------------------
    // Logic cells
    // -----------------------------------------------------------------

    wire [`NUM_CELLS-1:0] cellD;
    wire [`NUM_CELLS-1:0] cellOut;
    wire [`NUM_CELLS-1:0] cellOe;
    wire [`NUM_CELLS-1:0] cellRegMode;

    genvar c;
    generate
        for (c = 0; c < `NUM_CELLS; c = c + 1) begin : gCell
            wire [`TERMS_PER_CELL-1:0] terms;
            wire ioMode;
            wire orOut;
            wire fbCtl;
            wire isEnd;
            wire noFb;

            assign terms = termVal[c*`TERMS_PER_CELL +: `TERMS_PER_CELL]; // [R1]

            // Product-term mux: I/O shapes give the eighth term to the enable
            assign ioMode = familySel & modeBits[c]; // [R2] [R13]
            assign orOut = ioMode ? |terms[`OE_TERM-1:0] : |terms; // [R1] [R15] [R17] [R19] [R20]

            // Polarity XOR ahead of both the flip-flop and the output mux
            assign cellD[c] = orOut ^ polBits[c]; // [R12]

            // Output mux: flip-flop only when registers are allowed
            assign cellRegMode[c] = ~regAllow & familySel & ~modeBits[c]; // [R3] [R11] [R15]
            assign cellOut[c] = cellRegMode[c] ? cellQ_reg[c] : cellD[c]; // [R3]

            // Enable mux, selected by family bit and mode bit
            assign cellOe[c] = familySel ?
                (modeBits[c] ? terms[`OE_TERM] : ~outEnablePin_n) : // [R7] [R8] [R19] [R20]
                ~modeBits[c]; // [R8] [R9] [R18]

            // End cells steer feedback from the register-allow bit instead
            assign isEnd = (c == `LEFT_END_CELL) || (c == `RIGHT_END_CELL);
            assign fbCtl = isEnd ? ~regAllow : familySel; // [R13]
            assign noFb = ((c == `NOFB_CELL_A) || (c == `NOFB_CELL_B)) & ~modeBits[c];

            // Feedback mux: register, own pin, or neighbour pin
            assign feedback[c] = fbCtl ?
                (modeBits[c] ? cellPinIn[c] : cellQ_reg[c]) : // [R16] [R19] [R20]
                (noFb ? 1'b0 : cellPinIn[c ^ 1]); // [R9] [R17] [R18]
        end
    endgenerate

    // -----------------------------------------------------------------
    // Cell flip-flops and pin drivers
    // -----------------------------------------------------------------

    wire clkPinRise = clockPin & ~clkPinPrev_reg;

    // Cell registers step only on a rising edge seen at the clock pin
    always @(posedge clock or negedge rstSafe_n) begin
        if (!rstSafe_n) begin
            clkPinPrev_reg <= 1'b0;
            cellQ_reg <= {`NUM_CELLS{1'b0}};
        end else begin
            clkPinPrev_reg <= clockPin;
            if (clkPinRise) begin
                cellQ_reg <= (cellRegMode & cellD) | (~cellRegMode & cellQ_reg); // [R16]
            end
        end
    end

    // Pins are re-timed once; drivers stay off during reset
    always @(posedge clock or negedge rstSafe_n) begin
        if (!rstSafe_n) begin
            cellPinOut <= {`NUM_CELLS{1'b0}};
            cellPinOe <= {`NUM_CELLS{1'b0}};
        end else begin
            cellPinOut <= cellOut;
            cellPinOe <= cellOe; // [R7] [R8] [R9]
        end
    end

    // -----------------------------------------------------------------
    // Bus slave: write path
    // -----------------------------------------------------------------

    reg awHeld_reg;
    reg wHeld_reg;
    reg [`ADDR_W-1:0] wrAddr_reg;
    reg [31:0] wrData_reg;
    reg [3:0] wrStrb_reg;

    wire awTake = awvalid & awready;
    wire wTake = wvalid & wready;
    wire doWrite = awHeld_reg & wHeld_reg & ~bvalid;
    wire awHeld_next = (awHeld_reg | awTake) & ~doWrite;
    wire wHeld_next = (wHeld_reg | wTake) & ~doWrite;
    wire bValid_next = doWrite | (bvalid & ~bready);

    // Byte-lane mask built from the held strobes
    wire [31:0] wrMask = {{8{wrStrb_reg[3]}}, {8{wrStrb_reg[2]}},
        {8{wrStrb_reg[1]}}, {8{wrStrb_reg[0]}}};
    wire isFuseWr = wrAddr_reg[`FUSE_TAG_HI:`FUSE_TAG_LO] == `FUSE_TAG;
    wire [5:0] wrTerm = wrAddr_reg[8:3];
    wire wrHalf = wrAddr_reg[2];
    wire wrCfg = wrAddr_reg == `OFF_CONFIG;
    wire wrStat = wrAddr_reg == `OFF_STATUS;
    wire [31:0] cfgMerge = ({{(32-`CFG_W){1'b0}}, config_reg} & ~wrMask) |
        (wrData_reg & wrMask);
    wire [31:0] fuseOld = {{(32-`NUM_SIG){1'b0}},
        (wrHalf ? fuseComp_reg[wrTerm] : fuseTrue_reg[wrTerm])};
    wire [31:0] fuseMerge = (fuseOld & ~wrMask) | (wrData_reg & wrMask);

    // Address and data are taken in either order; response follows both
    always @(posedge clock or negedge rstSafe_n) begin
        if (!rstSafe_n) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            wrAddr_reg <= {`ADDR_W{1'b0}};
            wrData_reg <= 32'h0000_0000;
            wrStrb_reg <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else begin
            awHeld_reg <= awHeld_next;
            wHeld_reg <= wHeld_next;
            if (awTake) begin
                wrAddr_reg <= awaddr;
            end
            if (wTake) begin
                wrData_reg <= wdata;
                wrStrb_reg <= wstrb;
            end
            awready <= ~awHeld_next & ~bValid_next;
            wready <= ~wHeld_next & ~bValid_next;
            bvalid <= bValid_next;
            if (doWrite) begin
                bresp <= (wrCfg | wrStat | isFuseWr) ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // Config and fuses; loaded while the array is idle, then left alone
    integer i;
    always @(posedge clock or negedge rstSafe_n) begin
        if (!rstSafe_n) begin
            config_reg <= `CFG_RESET;
            for (i = 0; i < `NUM_TERMS; i = i + 1) begin
                fuseTrue_reg[i] <= {`NUM_SIG{1'b0}};
                fuseComp_reg[i] <= {`NUM_SIG{1'b0}};
            end
        end else if (doWrite) begin
            if (wrCfg) begin
                config_reg <= cfgMerge[`CFG_W-1:0]; // [R10] [R21]
            end
            if (isFuseWr && !wrHalf) begin
                fuseTrue_reg[wrTerm] <= fuseMerge[`NUM_SIG-1:0];
            end
            if (isFuseWr && wrHalf) begin
                fuseComp_reg[wrTerm] <= fuseMerge[`NUM_SIG-1:0]; // [R4]
            end
        end
    end

    // -----------------------------------------------------------------
    // Bus slave: read path
    // -----------------------------------------------------------------

    wire arTake = arvalid & arready;
    wire rValid_next = arTake | (rvalid & ~rready);
    wire isFuseRd = araddr[`FUSE_TAG_HI:`FUSE_TAG_LO] == `FUSE_TAG;
    wire [5:0] rdTerm = araddr[8:3];
    wire [`NUM_SIG-1:0] rdFuse = araddr[2] ? fuseComp_reg[rdTerm] : fuseTrue_reg[rdTerm];

    // Status shows pin levels, cell registers and the two shared pins
    wire [31:0] statusWord = {14'h0000, ~outEnablePin_n, clockPin,
        cellQ_reg, cellPinIn};

    reg [31:0] rdWord;
    reg rdHit;

    // Read decode; unmapped words read zero with an error response
    always @* begin
        rdWord = 32'h0000_0000;
        rdHit = 1'b1;
        if (araddr == `OFF_CONFIG) begin
            rdWord = {{(32-`CFG_W){1'b0}}, config_reg};
        end else if (araddr == `OFF_STATUS) begin
            rdWord = statusWord;
        end else if (isFuseRd) begin
            rdWord = {{(32-`NUM_SIG){1'b0}}, rdFuse};
        end else begin
            rdHit = 1'b0;
        end
    end

    // Data are captured at the address handshake and held until taken
    always @(posedge clock or negedge rstSafe_n) begin
        if (!rstSafe_n) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else begin
            arready <= ~rValid_next;
            rvalid <= rValid_next;
            if (arTake) begin
                rdata <= rdWord;
                rresp <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

endmodule

`default_nettype wire

// File: logic_cell_array_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "logic_cell_array_defines.vh"
// ------
// Pin and bus checker
// ------
module logic_cell_array_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clockPin,
    input wire logic outEnablePin_n,
    input wire logic [`NUM_CELLS-1:0] cellPinOut,
    input wire logic [`NUM_CELLS-1:0] cellPinOe,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [`ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [31:0] wdata,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    logic [`CFG_W-1:0] cfg;
    logic [1:0] age;
    logic [7:0] inM, outM, regM;
    // Config shadow; age masks the cycles the pins lag a config write
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= `CFG_RESET;
            age <= 2'h3;
        end else if (awvalid && awready && wvalid && wready && awaddr == `OFF_CONFIG) begin
            cfg <= wdata[`CFG_W-1:0];
            age <= 2'h0;
        end else if (age != 2'h3) begin
            age <= age + 2'h1;
        end
    end
    // Cells per mode
    always_comb begin
        inM = (cfg[16] && !cfg[17]) ? cfg[7:0] : 8'h00;
        outM = (cfg[16] && !cfg[17]) ? ~cfg[7:0] : 8'h00;
        regM = (!cfg[16] && cfg[17]) ? ~cfg[7:0] : 8'h00;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence wrTaken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence wrAnswer;
        !bvalid ##1 bvalid;
    endsequence
    chk_write_answer: assert property (wrTaken |=> wrAnswer)
        else $error("write response not two cycles after take");
    chk_aw_blocked: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while response pending");
    chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read data not one cycle after take");
    chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
        else $error("read data dropped early");
    chk_input_off: assert property (age[1] |-> (cellPinOe & inM) == 8'h00)
        else $error("input cell drives its pin");
    chk_output_on: assert property (age[1] |-> (cellPinOe & outM) == outM)
        else $error("output cell not driving");
    chk_reg_enable: assert property (
        age == 2'h3 && $stable(outEnablePin_n)
        |-> (cellPinOe & regM) == (outEnablePin_n ? 8'h00 : regM))
        else $error("registered cell enable not from enable pin");
    chk_reg_hold: assert property (
        age == 2'h3 && $stable(clockPin) && $past(clockPin) == $past(clockPin, 2)
        && $past(clockPin, 2) == $past(clockPin, 3) |-> $stable(cellPinOut & regM))
        else $error("registered pin moved without clock rise");
endmodule

bind logic_cell_array logic_cell_array_checker chk (
    .clock, .rst_n, .clockPin, .outEnablePin_n, .cellPinOut, .cellPinOe,
    .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .bvalid, .bready, .bresp,
    .arvalid, .arready, .rvalid, .rready, .rdata, .rresp
);
`default_nettype wire

// File: logic_cell_array_defines.vh
`ifndef LOGIC_CELL_ARRAY_DEFINES_VH
`define LOGIC_CELL_ARRAY_DEFINES_VH

// -----------------------------------------------------------------
// Array geometry
// -----------------------------------------------------------------
`define NUM_CELLS 8
`define NUM_DIN 12
`define NUM_SIG 22
`define TERMS_PER_CELL 8
`define NUM_TERMS 64
`define OE_TERM 7
`define SIG_CLK 12
`define SIG_OE 13
`define SIG_FB_LSB 14
`define LEFT_END_CELL 0
`define RIGHT_END_CELL 7
`define NOFB_CELL_A 3
`define NOFB_CELL_B 4

// -----------------------------------------------------------------
// Register map (byte addresses)
// -----------------------------------------------------------------
`define ADDR_W 12
`define OFF_CONFIG 12'h000
`define OFF_STATUS 12'h004
`define FUSE_TAG_HI 11
`define FUSE_TAG_LO 9
`define FUSE_TAG 3'h2

// -----------------------------------------------------------------
// Configuration word fields and reset value
// -----------------------------------------------------------------
`define CFG_W 18
`define CFG_MODE_LSB 0
`define CFG_POL_LSB 8
`define CFG_REG_ALLOW_BIT 16
`define CFG_FAMILY_BIT 17
`define CFG_RESET 18'h1_00FF

// -----------------------------------------------------------------
// Status word fields and bus responses
// -----------------------------------------------------------------
`define STAT_PIN_LSB 0
`define STAT_Q_LSB 8
`define STAT_CLK_BIT 16
`define STAT_OE_BIT 17
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: pin_board.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Board logic on the cell pins
// ------
module pin_board (
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] boardVal,
    output logic [7:0] pinLevel
);
    // Board drives every pin the device released, so no pin floats
    assign pinLevel = (pinOut & pinOe) | (boardVal & ~pinOe);
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "logic_cell_array_defines.vh"
// ------
// Bench
// ------
module tb_top;
    logic clock = 1'b0;
    logic rst_n, clockPin, outEnablePin_n, awvalid, wvalid, bready, arvalid, rready, probe;
    logic [11:0] dataIn, awaddr, araddr;
    logic [7:0] boardVal;
    logic [31:0] wdata;
    wire awready, wready, bvalid, arready, rvalid;
    wire [7:0] cellPinIn, cellPinOut, cellPinOe;
    wire [31:0] rdata;
    wire [1:0] bresp, rresp;
    logic [33:0] expQ[$];
    logic [31:0] seed = 32'h0001_6F2A;
    int badCount = 0;
    int totalChecks = 0;
    int cycles = 0;
    always #5 clock = ~clock;
    logic_cell_array DUT (.clock, .rst_n, .dataIn, .clockPin, .outEnablePin_n, .cellPinIn,
        .cellPinOut, .cellPinOe, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
        .rready, .rdata, .rresp);
    pin_board PB (.pinOut(cellPinOut), .pinOe(cellPinOe), .boardVal, .pinLevel(cellPinIn));
    // Seed starts at 93994
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Output-mode cell sums before polarity, enable pin high and clock pin low;
    // cell 5 sums the level on cell 4's pin, so it needs cell 4's polarity
    function automatic logic [7:0] sumOut(input logic [11:0] d, input logic [7:0] p);
        return {2'h0, ~p[4], 3'h5, ~d[1], d[0] | d[2]};
    endfunction
    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        expQ.push_back({r, 32'h0000_0000});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        expQ.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        @(posedge clock);
    endtask
    // Pins need two clocks after inputs settle when fed back through a pin or the flip-flop; three leaves margin
    task automatic pins(input logic [15:0] e);
        repeat (3) @(posedge clock);
        expQ.push_back({18'h0_0000, e});
        probe <= 1'b1;
        @(posedge clock);
        probe <= 1'b0;
        @(posedge clock);
    endtask
    task automatic completeRun;
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Result watcher and hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (bvalid && bready) check("bresp", {bresp, 32'h0000_0000}, expQ.pop_front());
        if (rvalid && rready) check("rdata", {rresp, rdata}, expQ.pop_front());
        if (probe) check("pins", {18'h0_0000, cellPinOe, cellPinOut & cellPinOe},
            expQ.pop_front());
        if (cycles == 30000) begin
            badCount++;
            completeRun();
        end
    end
    // Main sequence
    initial begin
        logic [11:0] d;
        logic [7:0] pol;
        logic [7:0] q;
        seed = lfsr(seed);
        {rst_n, clockPin, outEnablePin_n, probe} <= 4'h2;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        {dataIn, awaddr, araddr, wdata} <= 68'h0;
        boardVal <= seed[7:0];
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(`OFF_CONFIG, 32'h0001_00FF, `RESP_OKAY);
        rd(`OFF_STATUS, {24'h00_0000, boardVal}, `RESP_OKAY);
        wr(12'h010, 32'hFFFF_FFFF, `RESP_SLVERR);
        rd(12'h010, 32'h0000_0000, `RESP_SLVERR);
        rd(`OFF_CONFIG, 32'h0001_00FF, `RESP_OKAY);
        pins(16'h0000);
        $display("test reset done");
        // Every term low, then a few terms opened
        for (int t = 0; t < 64; t++) begin
            wr(12'h400 + 12'(8 * t), 32'h0000_0001, `RESP_OKAY);
            wr(12'h404 + 12'(8 * t), 32'h0000_0001, `RESP_OKAY);
        end
        wr(12'h404, 32'h0000_0000, `RESP_OKAY);
        wr(12'h438, 32'h0000_0004, `RESP_OKAY);
        wr(12'h43C, 32'h0000_0000, `RESP_OKAY);
        wr(12'h440, 32'h0000_0000, `RESP_OKAY);
        wr(12'h444, 32'h0000_0002, `RESP_OKAY);
        wr(12'h498, 32'h0000_0000, `RESP_OKAY);
        wr(12'h49C, 32'h0000_0000, `RESP_OKAY);
        // Enable and clock columns as data; dead once registers are in use
        wr(12'h4C0, 32'h0000_0000, `RESP_OKAY);
        wr(12'h4C4, 32'h0000_2000, `RESP_OKAY);
        wr(12'h500, 32'h0000_0000, `RESP_OKAY);
        wr(12'h504, 32'h0000_1000, `RESP_OKAY);
        // Cell 5 reads its feedback column
        wr(12'h540, 32'h0008_0000, `RESP_OKAY);
        wr(12'h544, 32'h0000_0000, `RESP_OKAY);
        rd(12'h444, 32'h0000_0002, `RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            d = seed[11:0];
            pol = seed[19:12];
            dataIn <= d;
            if (i < 4) begin
                wr(`OFF_CONFIG, {14'h0000, 2'h1, pol, 8'h00}, `RESP_OKAY);
                pins({8'hFF, sumOut(d, pol) ^ pol});
            end else begin
                wr(`OFF_CONFIG, {14'h0000, i[0] ? 2'h3 : 2'h2, pol, 8'hFF}, `RESP_OKAY);
                pins({7'h00, d[2], 7'h00, (d[0] ^ pol[0]) & d[2]});
            end
        end
        $display("test combinatorial done");
        seed = lfsr(seed);
        d = seed[11:0];
        pol = seed[19:12];
        // Masked columns leave cells 3 and 4 empty, hence high; cell 5 sums Q
        q = {3'h0, 3'h7, ~d[1], d[0] | d[2]} ^ pol;
        outEnablePin_n <= 1'b0;
        dataIn <= d;
        wr(`OFF_CONFIG, {14'h0000, 2'h2, pol, 8'h00}, `RESP_OKAY);
        pins(16'hFF00);
        clockPin <= 1'b1;
        pins({8'hFF, q});
        dataIn <= ~d;
        pins({8'hFF, q});
        outEnablePin_n <= 1'b1;
        pins(16'h0000);
        rd(`OFF_STATUS, {14'h0000, 2'h1, q, boardVal}, `RESP_OKAY);
        clockPin <= 1'b0;
        $display("test registered done");
        completeRun();
    end
endmodule
`default_nettype wire
